/* File: hw/ssp_pkg.sv */
// Summary of operation
// - The system clock is divided by the programmed divisor to make the rate enable for the serial clock logic.
// - Bit zero of the stored divisor is held at zero by hardware, so the divisor is always even.
// - After an odd divisor is written, reading the prescale register returns it with bit zero cleared.
// - All interrupt mask bits reset to zero, so every source starts out masked.
// - Reading the interrupt mask register returns the stored mask bit of each source.
// - Writing one to a mask bit sets it and lets its source reach the masked status and the interrupt line.
// - Writing zero to a mask bit clears it and blocks its source from the masked status and the interrupt line.
// - The transmit condition holds while the transmit FIFO holds half its capacity or fewer entries.
// - The receive condition holds while the receive FIFO holds half its capacity or more entries.
// - The overrun condition becomes true when the receive FIFO overflows.

`default_nettype none

package ssp_pkg;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam logic [11:0] OFF_PRESCALE = 12'h010;
    localparam logic [11:0] OFF_MASK     = 12'h014;
    localparam logic [11:0] OFF_RAW      = 12'h018;
    localparam logic [11:0] OFF_MASKED   = 12'h01c;
    localparam logic [11:0] OFF_CLEAR    = 12'h020;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          DIV_W        = 8;
    localparam logic [7:0]  PRESCALE_RST = 8'h00;
    localparam logic [7:0]  DIV_MIN      = 8'h02;
    localparam logic [7:0]  DIV_MAX      = 8'hfe;
    localparam int          IRQ_N        = 4;
    localparam logic [3:0]  MASK_RST     = 4'h0;
    localparam int          BIT_TX       = 3;
    localparam int          BIT_RX       = 2;
    localparam int          BIT_RT       = 1;
    localparam int          BIT_ROR      = 0;
    localparam int          FIFO_DEPTH   = 8;

endpackage : ssp_pkg

`default_nettype wire

/* File: hw/ssp_prescale_irq.sv */
`timescale 1ns/1ns
`default_nettype none

module ssp_prescale_irq #(
    parameter int FIFO_DEPTH = ssp_pkg::FIFO_DEPTH,
    parameter int FILL_W     = $clog2(FIFO_DEPTH + 1)
) (
    input  wire logic [ssp_pkg::ADDR_W-1:0] regAddr,       // byte address
    input  wire logic [ssp_pkg::DATA_W-1:0] regWrData,     // write data
    input  wire logic                       regWr,         // write strobe
    input  wire logic                       regRd,         // read strobe
    output logic      [ssp_pkg::DATA_W-1:0] regRdData,     // read data, cycle after strobe
    input  wire logic                       clk_sys,       // system clock
    input  wire logic                       resetn,        // async reset, active low
    input  wire logic [FILL_W-1:0]          txFillCount,   // transmit FIFO entries
    input  wire logic [FILL_W-1:0]          rxFillCount,   // receive FIFO entries
    input  wire logic                       rxTimeoutEvt,  // receive time-out pulse
    input  wire logic                       rxOverflowEvt, // receive overflow pulse
    output logic                            bitRateEn,     // prescaled rate enable pulse
    output logic      [ssp_pkg::IRQ_N-1:0]  maskedStatus,  // masked interrupt status
    output logic                            irqOut         // interrupt, active high level
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ssp_pkg::DIV_W-1:0]  prescale;
        logic [ssp_pkg::IRQ_N-1:0]  mask;
        logic                       rtSticky;
        logic                       rorSticky;
        logic [ssp_pkg::IRQ_N-1:0]  masked;
        logic                       irq;
        logic [ssp_pkg::DATA_W-1:0] rdata;
    } ssp_regs_t;

    ssp_regs_t regs_ff;
    ssp_regs_t nxt_regs;

    localparam logic [FILL_W-1:0] HALF_FILL = FILL_W'(FIFO_DEPTH / 2);

    logic                      wrPrescale;
    logic                      wrMask;
    logic                      wrClear;
    logic                      txCond;
    logic                      rxCond;
    logic [ssp_pkg::IRQ_N-1:0] rawNow;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // writes to read-only or unmapped offsets are dropped silently
    always_comb begin
        wrPrescale = 1'b0;
        wrMask     = 1'b0;
        wrClear    = 1'b0;
        if (regWr && regAddr == ssp_pkg::OFF_PRESCALE) begin
            wrPrescale = 1'b1;
        end else if (regWr && regAddr == ssp_pkg::OFF_MASK) begin
            wrMask = 1'b1;
        end else if (regWr && regAddr == ssp_pkg::OFF_CLEAR) begin
            wrClear = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // raw conditions
    // ------------------------------------------------------------
    // fifo levels are live conditions; time-out and overrun are events, kept sticky
    assign txCond = (txFillCount <= HALF_FILL);
    assign rxCond = (rxFillCount >= HALF_FILL);

    // bit order follows the mask layout
    assign rawNow = {txCond, rxCond, regs_ff.rtSticky, regs_ff.rorSticky};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_regs = regs_ff;

        // bit zero never stored, so any odd write reads back even
        if (wrPrescale) begin
            nxt_regs.prescale = {regWrData[ssp_pkg::DIV_W-1:1], 1'b0};
        end

        // mask takes each written bit as-is: one unmasks, zero masks
        if (wrMask) begin
            nxt_regs.mask = regWrData[ssp_pkg::IRQ_N-1:0];
        end

        // set beats clear so an event in the clearing cycle survives
        nxt_regs.rtSticky = rxTimeoutEvt
                          | (regs_ff.rtSticky & ~(wrClear & regWrData[ssp_pkg::BIT_RT]));
        nxt_regs.rorSticky = rxOverflowEvt
                           | (regs_ff.rorSticky & ~(wrClear & regWrData[ssp_pkg::BIT_ROR]));

        // masked status and interrupt computed from next values: outputs stay registered
        nxt_regs.masked = {txCond, rxCond, nxt_regs.rtSticky, nxt_regs.rorSticky} & nxt_regs.mask;
        nxt_regs.irq    = |nxt_regs.masked;

        // read data valid only in the cycle after the strobe
        nxt_regs.rdata = '0;
        if (regRd) begin
            if (regAddr == ssp_pkg::OFF_PRESCALE) begin
                nxt_regs.rdata = {{(ssp_pkg::DATA_W-ssp_pkg::DIV_W){1'b0}}, regs_ff.prescale};
            end else if (regAddr == ssp_pkg::OFF_MASK) begin
                nxt_regs.rdata = {{(ssp_pkg::DATA_W-ssp_pkg::IRQ_N){1'b0}}, regs_ff.mask};
            end else if (regAddr == ssp_pkg::OFF_RAW) begin
                nxt_regs.rdata = {{(ssp_pkg::DATA_W-ssp_pkg::IRQ_N){1'b0}}, rawNow};
            end else if (regAddr == ssp_pkg::OFF_MASKED) begin
                nxt_regs.rdata = {{(ssp_pkg::DATA_W-ssp_pkg::IRQ_N){1'b0}}, rawNow & regs_ff.mask};
            end else begin
                nxt_regs.rdata = '0;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            regs_ff           <= '0;
            regs_ff.prescale  <= ssp_pkg::PRESCALE_RST;
            regs_ff.mask      <= ssp_pkg::MASK_RST;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign regRdData    = regs_ff.rdata;
    assign maskedStatus = regs_ff.masked;
    assign irqOut       = regs_ff.irq;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // divisor read straight from the register: a rewrite takes effect at once
    ssp_prescaler #(
        .DIV_W   (ssp_pkg::DIV_W)
    ) u_prescaler (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .divisor (regs_ff.prescale),
        .rateEn  (bitRateEn)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic       afterReset_ff;
    logic [7:0] lastDivWrite_ff;

    // first edge after release, and the last value written to the prescaler
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            afterReset_ff   <= 1'b1;
            lastDivWrite_ff <= 8'h00;
        end else begin
            afterReset_ff <= 1'b0;
            if (wrPrescale) begin
                lastDivWrite_ff <= regWrData[7:0];
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence seqDivWrite;
        regWr && regAddr == ssp_pkg::OFF_PRESCALE;
    endsequence

    sequence seqDivRead;
        regRd && regAddr == ssp_pkg::OFF_PRESCALE;
    endsequence

    sequence seqMaskRead;
        regRd && regAddr == ssp_pkg::OFF_MASK;
    endsequence

    sequence seqRawRead;
        regRd && regAddr == ssp_pkg::OFF_RAW;
    endsequence

    sequence seqMaskedRead;
        regRd && regAddr == ssp_pkg::OFF_MASKED;
    endsequence

    // a clear of the overrun flag with no new overflow beside it
    sequence seqClearRor;
        wrClear && regWrData[ssp_pkg::BIT_ROR] && !rxOverflowEvt;
    endsequence

    prescale_even_a: assert property (regs_ff.prescale[0] == 1'b0)
        else $error("stored divisor is odd");

    odd_readback_a: assert property (seqDivWrite ##1 seqDivRead
        |=> regRdData == {24'h000000, lastDivWrite_ff[7:1], 1'b0})
        else $error("divisor readback not written value with bit zero cleared");

    mask_reset_a: assert property (afterReset_ff |-> regs_ff.mask == 4'h0 && !irqOut)
        else $error("mask not zero after reset");

    mask_read_a: assert property (seqMaskRead
        |=> regRdData == {28'h0000000, $past(regs_ff.mask)})
        else $error("mask readback differs from stored mask");

    mask_set_a: assert property ((wrMask && regWrData[ssp_pkg::BIT_TX])
        |=> regs_ff.mask[ssp_pkg::BIT_TX] && maskedStatus[ssp_pkg::BIT_TX] == $past(txCond))
        else $error("mask bit write of one not effective");

    mask_clear_a: assert property ((wrMask && !regWrData[ssp_pkg::BIT_ROR])
        |=> !regs_ff.mask[ssp_pkg::BIT_ROR] && !maskedStatus[ssp_pkg::BIT_ROR])
        else $error("mask bit write of zero did not block source");

    irq_level_a: assert property (irqOut == (|maskedStatus))
        else $error("interrupt disagrees with masked status");

    tx_cond_a: assert property ((txFillCount <= HALF_FILL) && !wrMask && regs_ff.mask[ssp_pkg::BIT_TX]
        |=> maskedStatus[ssp_pkg::BIT_TX] && irqOut)
        else $error("transmit half empty not signalled");

    rx_cond_a: assert property ((rxFillCount < HALF_FILL)
        |=> !maskedStatus[ssp_pkg::BIT_RX])
        else $error("receive half full signalled below half");

    overrun_a: assert property (rxOverflowEvt && !wrMask && regs_ff.mask[ssp_pkg::BIT_ROR]
        |=> maskedStatus[ssp_pkg::BIT_ROR] && irqOut)
        else $error("overflow not flagged despite clear in same cycle");

    // ------------------------------------------------------------
    // checks: register contents, read path and sticky flags
    // ------------------------------------------------------------
    // each check looks one edge after its cause, as the registered outputs do

    rdata_idle_a: assert property (!regRd
        |=> regRdData == 32'h00000000)
        else $error("read data not zero outside the answer cycle");

    prescale_store_a: assert property (seqDivWrite
        |=> regs_ff.prescale == {$past(regWrData[7:1]), 1'b0})
        else $error("stored divisor differs from written value");

    prescale_hold_a: assert property (!wrPrescale
        |=> $stable(regs_ff.prescale))
        else $error("divisor changed without a write");

    mask_store_a: assert property (wrMask
        |=> regs_ff.mask == $past(regWrData[ssp_pkg::IRQ_N-1:0]))
        else $error("stored mask differs from written value");

    mask_hold_a: assert property (!wrMask
        |=> $stable(regs_ff.mask))
        else $error("mask changed without a write");

    status_map_a: assert property (1'b1
        |=> maskedStatus == ({$past(txCond), $past(rxCond), regs_ff.rtSticky, regs_ff.rorSticky} & regs_ff.mask))
        else $error("masked status not raw conditions and mask");

    tx_block_a: assert property ((txFillCount > HALF_FILL)
        |=> !maskedStatus[ssp_pkg::BIT_TX])
        else $error("transmit source signalled above half");

    rx_cond_set_a: assert property ((rxFillCount >= HALF_FILL) && !wrMask && regs_ff.mask[ssp_pkg::BIT_RX]
        |=> maskedStatus[ssp_pkg::BIT_RX] && irqOut)
        else $error("receive half full not signalled");

    irq_quiet_a: assert property ((regs_ff.mask == 4'h0) && !wrMask
        |=> !irqOut)
        else $error("interrupt raised with every source masked");

    ror_set_a: assert property (rxOverflowEvt
        |=> regs_ff.rorSticky)
        else $error("overflow event lost");

    rt_set_a: assert property (rxTimeoutEvt
        |=> regs_ff.rtSticky)
        else $error("time-out event lost");

    ror_clear_a: assert property (seqClearRor
        |=> !regs_ff.rorSticky)
        else $error("overrun flag not cleared");

    rt_clear_a: assert property (wrClear && regWrData[ssp_pkg::BIT_RT] && !rxTimeoutEvt
        |=> !regs_ff.rtSticky)
        else $error("time-out flag not cleared");

    ror_hold_a: assert property (regs_ff.rorSticky && !wrClear
        |=> regs_ff.rorSticky)
        else $error("overrun flag dropped without a clear");

    raw_read_a: assert property (seqRawRead
        |=> regRdData == {28'h0000000, $past(rawNow)})
        else $error("raw status readback differs");

    masked_read_a: assert property (seqMaskedRead
        |=> regRdData == {28'h0000000, $past(rawNow & regs_ff.mask)})
        else $error("masked status readback differs");

endmodule : ssp_prescale_irq

`default_nettype wire

/* File: hw/ssp_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none

module ssp_prescaler #(
    parameter int DIV_W = ssp_pkg::DIV_W
) (
    input  wire logic             clk_sys,  // system clock
    input  wire logic             resetn,   // async reset, active low
    input  wire logic [DIV_W-1:0] divisor,  // even divisor, zero halts
    output logic                  rateEn    // one-cycle pulse every divisor cycles
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic             pulse;
    } ssp_div_t;

    ssp_div_t cur_ff;
    ssp_div_t nxt_cur;

    // divider: compare with >= so a divisor shrunk mid-period cannot overrun
    always_comb begin
        nxt_cur = cur_ff;
        if (divisor == '0) begin
            nxt_cur.count = '0;
            nxt_cur.pulse = 1'b0;
        end else if (cur_ff.count >= divisor - 1'b1) begin
            nxt_cur.count = '0;
            nxt_cur.pulse = 1'b1;
        end else begin
            nxt_cur.count = cur_ff.count + 1'b1;
            nxt_cur.pulse = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign rateEn = cur_ff.pulse;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [DIV_W:0]   gapCnt_ff;
    logic [DIV_W-1:0] prevDiv_ff;
    logic             divMoved_ff;
    logic             seenPulse_ff;

    // cycles since the last pulse, and whether the divisor moved meanwhile
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gapCnt_ff    <= '0;
            prevDiv_ff   <= '0;
            divMoved_ff  <= 1'b0;
            seenPulse_ff <= 1'b0;
        end else begin
            prevDiv_ff <= divisor;
            if (rateEn) begin
                gapCnt_ff    <= {{DIV_W{1'b0}}, 1'b1};
                divMoved_ff  <= 1'b0;
                seenPulse_ff <= 1'b1;
            end else begin
                gapCnt_ff   <= gapCnt_ff + 1'b1;
                divMoved_ff <= divMoved_ff | (divisor != prevDiv_ff);
            end
        end
    end

    rate_period_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rateEn && seenPulse_ff && !divMoved_ff && divisor != '0 && divisor == prevDiv_ff)
        |-> gapCnt_ff == {1'b0, divisor})
        else $error("rate enable period differs from divisor");

    rate_halt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (divisor == '0) [*2] |-> !rateEn)
        else $error("rate enable pulses with divisor zero");

endmodule : ssp_prescaler

`default_nettype wire

/* File: verif/ssp_far_model.sv */
`timescale 1ns/1ns
`default_nettype none

module ssp_far_model #(
    parameter int FILL_W = 4
) (
    input  wire logic             clk_sys,       // system clock
    input  wire logic             resetn,        // async reset, active low
    input  wire logic             bitRateEn,     // rate pulse from the prescaler
    output var  logic [FILL_W-1:0] txFillCount,  // transmit fifo entries
    output var  logic [FILL_W-1:0] rxFillCount,  // receive fifo entries
    output var  logic             rxTimeoutEvt,  // time-out pulse
    output var  logic             rxOverflowEvt, // overflow pulse
    output var  logic [15:0]      lastPeriod     // cycles between the last two rate pulses
);
    logic [15:0] gapCnt; // cycles since the last rate pulse

    // fifos start empty and quiet
    initial begin
        txFillCount   = '0;
        rxFillCount   = '0;
        rxTimeoutEvt  = 1'b0;
        rxOverflowEvt = 1'b0;
    end

    // fill levels move only after an edge, as a real fifo counter would
    task automatic set_fill(input logic [FILL_W-1:0] tx, input logic [FILL_W-1:0] rx);
        @(posedge clk_sys);
        txFillCount <= tx;
        rxFillCount <= rx;
    endtask : set_fill

    // one-cycle event: overflow when sel is high, time-out otherwise
    task automatic pulse(input logic sel);
        @(posedge clk_sys);
        rxOverflowEvt <= sel;
        rxTimeoutEvt  <= ~sel;
        @(posedge clk_sys);
        rxOverflowEvt <= 1'b0;
        rxTimeoutEvt  <= 1'b0;
    endtask : pulse

    // period meter: the consumer only cares about spacing, not phase
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gapCnt     <= 16'h0000;
            lastPeriod <= 16'h0000;
        end else if (bitRateEn) begin
            lastPeriod <= gapCnt + 16'h0001;
            gapCnt     <= 16'h0000;
        end else begin
            gapCnt <= gapCnt + 16'h0001;
        end
    end
endmodule : ssp_far_model

`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic                        clk_sys   = 1'b0;
    logic                        resetn    = 1'b0;
    logic [ssp_pkg::ADDR_W-1:0]  regAddr   = 12'h000;
    logic [ssp_pkg::DATA_W-1:0]  regWrData = 32'h0000_0000;
    logic                        regWr     = 1'b0;
    logic                        regRd     = 1'b0;
    logic [ssp_pkg::DATA_W-1:0]  regRdData;
    logic                        bitRateEn;
    logic [ssp_pkg::IRQ_N-1:0]   maskedStatus;
    logic                        irqOut;
    logic [3:0]                  txFillCount;
    logic [3:0]                  rxFillCount;
    logic                        rxTimeoutEvt;
    logic                        rxOverflowEvt;
    logic [15:0]                 lastPeriod;
    int                          n_errors  = 0;
    int                          n_checks  = 0;
    logic [7:0]                  divs [3]  = '{8'h04, 8'h02, 8'hfe};

    always #2 clk_sys = ~clk_sys;

    ssp_prescale_irq #(.FIFO_DEPTH(8)) u_ssp_prescale_irq (
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .clk_sys(clk_sys), .resetn(resetn), .txFillCount(txFillCount), .rxFillCount(rxFillCount),
        .rxTimeoutEvt(rxTimeoutEvt), .rxOverflowEvt(rxOverflowEvt), .bitRateEn(bitRateEn),
        .maskedStatus(maskedStatus), .irqOut(irqOut));

    ssp_far_model #(.FILL_W(4)) u_ssp_far_model (
        .clk_sys(clk_sys), .resetn(resetn), .bitRateEn(bitRateEn), .txFillCount(txFillCount),
        .rxFillCount(rxFillCount), .rxTimeoutEvt(rxTimeoutEvt), .rxOverflowEvt(rxOverflowEvt),
        .lastPeriod(lastPeriod));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe, so look there
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask : rd

    // three edges cover the one-cycle status latency with margin
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic lvl(input logic [3:0] tx, input logic [3:0] rx, input logic [3:0] exp);
        u_ssp_far_model.set_fill(tx, rx);
        settle();
        chk({28'h0, maskedStatus}, {28'h0, exp});
    endtask : lvl

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(ssp_pkg::OFF_PRESCALE, 32'h0000_0000);
        rd(ssp_pkg::OFF_MASK, 32'h0000_0000);
        chk({31'h0, irqOut}, 32'h0000_0000);
    endtask : t_reset

    // odd values lose bit zero; an unmapped address reads as zero
    task automatic t_prescale();
        wr(ssp_pkg::OFF_PRESCALE, 32'h0000_0107);
        rd(ssp_pkg::OFF_PRESCALE, 32'h0000_0006);
        wr(ssp_pkg::OFF_PRESCALE, 32'h0000_00ff);
        rd(ssp_pkg::OFF_PRESCALE, 32'h0000_00fe);
        rd(12'h02c, 32'h0000_0000);
    endtask : t_prescale

    // a divisor change takes effect mid-period, so skip a few periods first
    task automatic t_rate();
        for (int i = 0; i < 3; i++) begin
            wr(ssp_pkg::OFF_PRESCALE, {24'h0, divs[i]});
            repeat (3 * divs[i] + 4) @(posedge clk_sys);
            #1;
            chk({16'h0, lastPeriod}, {24'h0, divs[i]});
        end
    endtask : t_rate

    // all four sources active, then each mask bit opened alone
    task automatic t_mask();
        u_ssp_far_model.set_fill(4'h0, 4'h8);
        u_ssp_far_model.pulse(1'b0);
        u_ssp_far_model.pulse(1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(ssp_pkg::OFF_MASK, 32'h1 << i);
            settle();
            chk({28'h0, maskedStatus}, 32'h1 << i);
            chk({31'h0, irqOut}, 32'h0000_0001);
            rd(ssp_pkg::OFF_MASK, 32'h1 << i);
        end
        wr(ssp_pkg::OFF_MASK, 32'h0000_0000);
        settle();
        chk({28'h0, maskedStatus}, 32'h0000_0000);
        chk({31'h0, irqOut}, 32'h0000_0000);
    endtask : t_mask

    // fill boundaries sit exactly at half of the depth of eight
    task automatic t_levels();
        wr(ssp_pkg::OFF_MASK, 32'h0000_000c);
        lvl(4'h4, 4'h4, 4'hc);
        lvl(4'h5, 4'h3, 4'h0);
        lvl(4'h4, 4'h3, 4'h8);
        lvl(4'h5, 4'h4, 4'h4);
    endtask : t_levels

    // overrun is sticky until a one is written to its clear bit
    task automatic t_overrun();
        wr(ssp_pkg::OFF_CLEAR, 32'h0000_0003);
        wr(ssp_pkg::OFF_MASK, 32'h0000_0001);
        settle();
        chk({28'h0, maskedStatus}, 32'h0000_0000);
        u_ssp_far_model.pulse(1'b1);
        settle();
        chk({28'h0, maskedStatus}, 32'h0000_0001);
        chk({31'h0, irqOut}, 32'h0000_0001);
        rd(ssp_pkg::OFF_RAW, 32'h0000_0005);
        rd(ssp_pkg::OFF_MASKED, 32'h0000_0001);
        wr(ssp_pkg::OFF_CLEAR, 32'h0000_0001);
        settle();
        chk({31'h0, irqOut}, 32'h0000_0000);
        // overflow and clear in one cycle: the new event has to survive
        fork
            u_ssp_far_model.pulse(1'b1);
            wr(ssp_pkg::OFF_CLEAR, 32'h0000_0001);
        join
        settle();
        chk({28'h0, maskedStatus}, 32'h0000_0001);
        wr(ssp_pkg::OFF_CLEAR, 32'h0000_0001);
        settle();
        chk({28'h0, maskedStatus}, 32'h0000_0000);
    endtask : t_overrun

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // main sequence, reset held for two cycles
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_prescale();
        t_rate();
        t_mask();
        t_levels();
        t_overrun();
        wrap_up();
    end

    // whole run is under a thousand cycles; this is well past it
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
endmodule : tb

`default_nettype wire
